// File: core/phase_selector.sv
`timescale 1ns/1ps
`default_nettype none
module phase_selector (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    ref_rise,
  input  wire logic                    ref_fall,
  input  wire logic                    data_edge,
  output serial_port_pkg::phase_t      phase,
  output logic                         switch_pulse
);
  import serial_port_pkg::*;

  logic [GAP_W-1:0]  since_rise_ff;
  logic [GAP_W-1:0]  since_fall_ff;
  logic [VOTE_W-1:0] vote_ff;
  phase_t            phase_ff;
  logic              switch_ff;
  logic [GAP_W-1:0]  nxt_since_rise;
  logic [GAP_W-1:0]  nxt_since_fall;
  logic [VOTE_W-1:0] nxt_vote;
  phase_t            nxt_phase;
  logic              nxt_switch;
  logic              near_rise;

  always_comb begin
    nxt_since_rise = ref_rise ? '0 : (since_rise_ff == GAP_MAX ? GAP_MAX : since_rise_ff + 8'h01);
    nxt_since_fall = ref_fall ? '0 : (since_fall_ff == GAP_MAX ? GAP_MAX : since_fall_ff + 8'h01);
    near_rise      = since_rise_ff < since_fall_ff;
    nxt_vote       = vote_ff;
    nxt_phase      = phase_ff;
    nxt_switch     = 1'b0;
    if (data_edge) begin
      if (near_rise && vote_ff != VOTE_MAX) begin
        nxt_vote = vote_ff + 3'h1;
      end else if (!near_rise && vote_ff != 3'h0) begin
        nxt_vote = vote_ff - 3'h1;
      end
    end
    unique case (phase_ff)
      PH_RISE: begin
        if (nxt_vote == VOTE_MAX) begin
          nxt_phase = PH_FALL;
          nxt_vote  = VOTE_MID;
          nxt_switch = 1'b1;
        end
      end
      PH_FALL: begin
        if (nxt_vote == 3'h0) begin
          nxt_phase  = PH_RISE;
          nxt_vote   = VOTE_MID;
          nxt_switch = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      since_rise_ff <= GAP_MAX;
      since_fall_ff <= GAP_MAX;
      vote_ff       <= VOTE_MID;
      phase_ff      <= PH_RISE;
      switch_ff     <= 1'b0;
    end else begin
      since_rise_ff <= nxt_since_rise;
      since_fall_ff <= nxt_since_fall;
      vote_ff       <= nxt_vote;
      phase_ff      <= nxt_phase;
      switch_ff     <= nxt_switch;
    end
  end

  assign phase        = phase_ff;
  assign switch_pulse = switch_ff;

endmodule
`default_nettype wire

// File: core/serial_port_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_top (
  input  wire logic                             clock,
  input  wire logic                             arst_n,
  input  wire serial_port_pkg::bus_req_t        bus_req,
  output logic [serial_port_pkg::DATA_W-1:0]    rdata,
  input  wire serial_port_pkg::pins_t           pins_in,
  input  wire logic                             rx_half_tick,
  output logic                                  int_tx_clk_out,
  output logic                                  tx_bit,
  output logic                                  tx_bit_valid,
  output logic                                  carrier_on,
  output logic                                  handshake_alarm,
  output logic                                  irq
);
  import serial_port_pkg::*;

  // reset release
  logic [1:0]        rst_sync_ff;
  logic              rst_n;

  // synchronised pins and their previous values
  pins_t             pins_s;
  pins_t             pins_prev_ff;

  // internal transmit clock
  logic [DIV_W-1:0]  div_cnt_ff;
  logic              int_clk_ff;
  logic              int_prev_ff;
  logic [DIV_W-1:0]  nxt_div_cnt;
  logic              nxt_int_clk;

  // registers
  ctrl_t             ctrl_ff;
  logic [DIV_W-1:0]  clkdiv_ff;
  logic [EVT_W-1:0]  int_en_ff;
  logic [EVT_W-1:0]  int_st_ff;
  logic [DATA_W-1:0] rdata_ff;
  ctrl_t             nxt_ctrl;
  logic [DIV_W-1:0]  nxt_clkdiv;
  logic [EVT_W-1:0]  nxt_int_en;
  logic [EVT_W-1:0]  nxt_int_st;
  logic [DATA_W-1:0] nxt_rdata;
  logic [EVT_W-1:0]  clear_mask;
  logic [EVT_W-1:0]  evt;
  logic [DATA_W-1:0] status_word;

  // outputs
  logic              tx_bit_ff;
  logic              tx_valid_ff;
  logic              carrier_ff;
  logic              alarm_ff;
  logic              irq_ff;
  logic              nxt_tx_bit;
  logic              nxt_tx_valid;
  logic              nxt_carrier;
  logic              nxt_alarm;
  logic              nxt_irq;

  // sampling reference
  logic              ref_rise;
  logic              ref_fall;
  logic              data_edge;
  logic              sel_edge;
  phase_t            phase;
  logic              phase_switch;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  sync_bits #(
    .WIDTH ($bits(pins_t))
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .din   (pins_in),
    .dout  (pins_s)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pins_prev_ff <= '0;
      int_prev_ff  <= 1'b0;
    end else begin
      pins_prev_ff <= pins_s;
      int_prev_ff  <= int_clk_ff;
    end
  end

  // internal clock: divider, or half-period ticks from the receive side
  always_comb begin
    nxt_div_cnt = div_cnt_ff;
    nxt_int_clk = int_clk_ff;
    if (ctrl_ff.clk_src == SRC_RX) begin
      nxt_div_cnt = '0;
      if (rx_half_tick) begin
        nxt_int_clk = ~int_clk_ff;
      end
    end else if (div_cnt_ff >= clkdiv_ff) begin
      nxt_div_cnt = '0;
      nxt_int_clk = ~int_clk_ff;
    end else begin
      nxt_div_cnt = div_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_ff <= '0;
      int_clk_ff <= 1'b0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      int_clk_ff <= nxt_int_clk;
    end
  end

  // reference edges by clocking mode
  always_comb begin
    if (ctrl_ff.clk_src == SRC_EXT) begin
      ref_rise = pins_s.tx_clk & ~pins_prev_ff.tx_clk;
      ref_fall = ~pins_s.tx_clk & pins_prev_ff.tx_clk;
    end else begin
      ref_rise = int_clk_ff & ~int_prev_ff;
      ref_fall = ~int_clk_ff & int_prev_ff;
    end
    data_edge = pins_s.tx_data ^ pins_prev_ff.tx_data;
  end

  phase_selector u_phase (
    .clock        (clock),
    .rst_n        (rst_n),
    .ref_rise     (ref_rise),
    .ref_fall     (ref_fall),
    .data_edge    (data_edge),
    .phase        (phase),
    .switch_pulse (phase_switch)
  );

  // data sampling and line outputs
  always_comb begin
    sel_edge     = (phase == PH_FALL) ? ref_fall : ref_rise;
    nxt_tx_bit   = sel_edge ? pins_s.tx_data : tx_bit_ff;
    nxt_tx_valid = sel_edge;
    nxt_carrier  = ctrl_ff.carrier_rts ? pins_s.rts : ctrl_ff.carrier_force;
    nxt_alarm    = ctrl_ff.alarm_en & (~pins_s.rts | ~pins_s.dtr);
    nxt_irq      = |(int_st_ff & int_en_ff);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_bit_ff   <= 1'b0;
      tx_valid_ff <= 1'b0;
      carrier_ff  <= 1'b0;
      alarm_ff    <= 1'b0;
      irq_ff      <= 1'b0;
    end else begin
      tx_bit_ff   <= nxt_tx_bit;
      tx_valid_ff <= nxt_tx_valid;
      carrier_ff  <= nxt_carrier;
      alarm_ff    <= nxt_alarm;
      irq_ff      <= nxt_irq;
    end
  end

  // register file
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_clkdiv = clkdiv_ff;
    nxt_int_en = int_en_ff;
    clear_mask = '0;
    nxt_rdata  = '0;
    evt        = '0;
    evt[EVT_PHASE] = phase_switch;
    evt[EVT_RTS]   = ctrl_ff.alarm_en & pins_prev_ff.rts & ~pins_s.rts;
    evt[EVT_DTR]   = ctrl_ff.alarm_en & pins_prev_ff.dtr & ~pins_s.dtr;

    status_word = '0;
    status_word[ST_PHASE_BIT]   = phase;
    status_word[ST_RTS_BIT]     = pins_s.rts;
    status_word[ST_DTR_BIT]     = pins_s.dtr;
    status_word[ST_CARRIER_BIT] = carrier_ff;
    status_word[ST_ALARM_BIT]   = alarm_ff;

    if (bus_req.wr) begin
      unique case (bus_req.addr)
        OFS_CTRL: begin
          nxt_ctrl.clk_src       = clk_src_t'(bus_req.wdata[CTRL_SRC_LSB +: 2]);
          nxt_ctrl.alarm_en      = bus_req.wdata[CTRL_ALARM_BIT];
          nxt_ctrl.carrier_rts   = bus_req.wdata[CTRL_RTS_BIT];
          nxt_ctrl.carrier_force = bus_req.wdata[CTRL_FORCE_BIT];
        end
        OFS_CLKDIV: nxt_clkdiv = bus_req.wdata[DIV_W-1:0];
        OFS_INT_EN: nxt_int_en = bus_req.wdata[EVT_W-1:0];
        OFS_INT_CL: clear_mask = bus_req.wdata[EVT_W-1:0];
        default: ;
      endcase
    end

    // set wins over a clear in the same cycle
    nxt_int_st = (int_st_ff & ~clear_mask) | evt;

    if (bus_req.rd) begin
      unique case (bus_req.addr)
        OFS_CTRL: begin
          nxt_rdata[CTRL_SRC_LSB +: 2] = ctrl_ff.clk_src;
          nxt_rdata[CTRL_ALARM_BIT]    = ctrl_ff.alarm_en;
          nxt_rdata[CTRL_RTS_BIT]      = ctrl_ff.carrier_rts;
          nxt_rdata[CTRL_FORCE_BIT]    = ctrl_ff.carrier_force;
        end
        OFS_CLKDIV: nxt_rdata[DIV_W-1:0] = clkdiv_ff;
        OFS_STATUS: nxt_rdata = status_word;
        OFS_INT_ST: nxt_rdata[EVT_W-1:0] = int_st_ff;
        OFS_INT_EN: nxt_rdata[EVT_W-1:0] = int_en_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff   <= CTRL_RST;
      clkdiv_ff <= CLKDIV_RST;
      int_en_ff <= INT_EN_RST;
      int_st_ff <= '0;
      rdata_ff  <= '0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      clkdiv_ff <= nxt_clkdiv;
      int_en_ff <= nxt_int_en;
      int_st_ff <= nxt_int_st;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign rdata           = rdata_ff;
  assign int_tx_clk_out  = int_clk_ff;
  assign tx_bit          = tx_bit_ff;
  assign tx_bit_valid    = tx_valid_ff;
  assign carrier_on      = carrier_ff;
  assign handshake_alarm = alarm_ff;
  assign irq             = irq_ff;

endmodule
`default_nettype wire

// File: core/sync_bits.sv
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  // two flops per pin, first stage read only by the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        meta_ff[i] <= 1'b0;
        hold_ff[i] <= 1'b0;
      end else begin
        meta_ff[i] <= din[i];
        hold_ff[i] <= meta_ff[i];
      end
    end
  end

  assign dout = hold_ff;

endmodule
`default_nettype wire

// File: include/serial_port_pkg.sv
// Overview of operation
// - sampling phase chosen and re-chosen automatically
// - every phase change raises a warning
// - external clock mode: sample against incoming clock
// - internal/rx mode: sample against driven clock
// - optional alarm on inactive handshake lines
// - rts-controlled mode: carrier follows the rts pin
`default_nettype none
package serial_port_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W  = 16;
  localparam int GAP_W  = 8;
  localparam int VOTE_W = 3;
  localparam int EVT_W  = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CLKDIV = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INT_ST = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_INT_EN = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_INT_CL = 8'h14;

  // control field positions
  localparam int CTRL_SRC_LSB   = 0;
  localparam int CTRL_ALARM_BIT = 2;
  localparam int CTRL_RTS_BIT   = 3;
  localparam int CTRL_FORCE_BIT = 4;

  // status field positions
  localparam int ST_PHASE_BIT   = 0;
  localparam int ST_RTS_BIT     = 1;
  localparam int ST_DTR_BIT     = 2;
  localparam int ST_CARRIER_BIT = 3;
  localparam int ST_ALARM_BIT   = 4;

  // event bit positions
  localparam int EVT_PHASE = 0;
  localparam int EVT_RTS   = 1;
  localparam int EVT_DTR   = 2;

  // reset values and counts
  localparam logic [DIV_W-1:0]  CLKDIV_RST = 16'h000c;
  localparam logic [EVT_W-1:0]  INT_EN_RST = 3'h0;
  localparam logic [VOTE_W-1:0] VOTE_MAX   = 3'h7;
  localparam logic [VOTE_W-1:0] VOTE_MID   = 3'h4;
  localparam logic [GAP_W-1:0]  GAP_MAX    = 8'hff;

  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0,
    SRC_RX       = 2'h1,
    SRC_EXT      = 2'h2
  } clk_src_t;

  typedef enum logic {
    PH_RISE = 1'b0,
    PH_FALL = 1'b1
  } phase_t;

  typedef struct packed {
    logic     carrier_force;
    logic     carrier_rts;
    logic     alarm_en;
    clk_src_t clk_src;
  } ctrl_t;

  localparam ctrl_t CTRL_RST = '{carrier_force: 1'b0, carrier_rts: 1'b0,
                                 alarm_en: 1'b0, clk_src: SRC_INTERNAL};

  typedef struct packed {
    logic dtr;
    logic rts;
    logic tx_data;
    logic tx_clk;
  } pins_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

endpackage
`default_nettype wire

// File: verification/serial_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module serial_port_monitor
  import serial_port_pkg::*;
(
  input wire logic                      clock,
  input wire logic                      arst_n,
  input wire serial_port_pkg::bus_req_t bus_req,
  input wire serial_port_pkg::pins_t    pins_in,
  input wire logic                      int_tx_clk_out,
  input wire logic                      tx_bit_valid,
  input wire logic                      carrier_on,
  input wire logic                      handshake_alarm,
  input wire logic                      irq
);
  ctrl_t            ctl_ff;
  logic [EVT_W-1:0] en_ff;
  // shadow of the writable control state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctl_ff <= CTRL_RST;
      en_ff  <= INT_EN_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == OFS_CTRL) ctl_ff <= ctrl_t'(bus_req.wdata[4:0]);
      if (bus_req.addr == OFS_INT_EN) en_ff <= bus_req.wdata[EVT_W-1:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_valid_once:
    assert property (tx_bit_valid |=> !tx_bit_valid) else $error("valid too long");
  a_ref_ext:
    assert property (tx_bit_valid && ctl_ff.clk_src == SRC_EXT && $past(ctl_ff.clk_src, 4) == SRC_EXT
      |-> $past(pins_in.tx_clk, 2) != $past(pins_in.tx_clk, 6)) else $error("bit without ext edge");
  a_ref_int:
    assert property (tx_bit_valid && ctl_ff.clk_src != SRC_EXT && $past(ctl_ff.clk_src, 4) != SRC_EXT
      |-> int_tx_clk_out != $past(int_tx_clk_out, 3)) else $error("bit without int edge");
  a_clk_hold:
    assert property ($changed(int_tx_clk_out) |=> $stable(int_tx_clk_out)) else $error("int clock glitch");
  a_alarm_on:
    assert property ((ctl_ff.alarm_en && !(pins_in.rts && pins_in.dtr))[*5] |-> handshake_alarm)
      else $error("alarm missing");
  a_alarm_off:
    assert property ((!ctl_ff.alarm_en)[*2] |-> !handshake_alarm) else $error("alarm while off");
  a_carrier_rts:
    assert property ((ctl_ff.carrier_rts && $stable(pins_in.rts))[*5] |-> carrier_on == pins_in.rts)
      else $error("carrier not following rts");
  a_carrier_frc:
    assert property ((!ctl_ff.carrier_rts && $stable(ctl_ff.carrier_force))[*2]
      |-> carrier_on == ctl_ff.carrier_force) else $error("carrier not forced");
  a_irq_mask:
    assert property ((en_ff == '0)[*3] |-> !irq) else $error("irq while masked");
endmodule
bind serial_port_top serial_port_monitor i_serial_port_monitor (
  .clock(clock), .arst_n(arst_n), .bus_req(bus_req), .pins_in(pins_in),
  .int_tx_clk_out(int_tx_clk_out), .tx_bit_valid(tx_bit_valid), .carrier_on(carrier_on),
  .handshake_alarm(handshake_alarm), .irq(irq));
`default_nettype wire

// File: verification/sync_serial_terrestrial_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sync_serial_terrestrial_port_bench;
  import serial_port_pkg::*;
  logic              clock = 1'b0;
  logic              arst_n = 1'b0;
  bus_req_t          bus_req = '0;
  logic [DATA_W-1:0] rdata;
  pins_t             pins_in;
  logic              rx_half_tick = 1'b0;
  logic              int_tx_clk_out, tx_bit, tx_bit_valid, carrier_on, handshake_alarm, irq;
  logic              run = 1'b0, use_int = 1'b0, rts = 1'b1, dtr = 1'b1, tick_en = 1'b0;
  logic [3:0]        skew = 4'h1;
  logic [1:0]        tcnt = 2'h0;
  int                n_errors = 0;
  int                n_checks = 0;
  always #20 clock = ~clock;
  always @(posedge clock) begin
    tcnt <= tcnt + 2'h1;
    rx_half_tick <= tick_en && tcnt == 2'h3;
  end
  serial_port_top i_serial_port_top (.clock(clock), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
    .pins_in(pins_in), .rx_half_tick(rx_half_tick), .int_tx_clk_out(int_tx_clk_out), .tx_bit(tx_bit),
    .tx_bit_valid(tx_bit_valid), .carrier_on(carrier_on), .handshake_alarm(handshake_alarm), .irq(irq));
  term_model i_term_model (.clock(clock), .run(run), .use_int(use_int), .int_clk(int_tx_clk_out),
    .skew(skew), .rts(rts), .dtr(dtr), .pins(pins_in));
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= {a, d, 2'b10};
    @(posedge clock);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clock);
    bus_req <= {a, 32'h0, 2'b01};
    @(posedge clock);
    bus_req <= '0;
    #1 chk(what, exp, rdata);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic wait_irq();
    int i;
    for (i = 0; i < 600 && irq !== 1'b1; i++) @(negedge clock);
    if (irq !== 1'b1) begin
      n_errors++;
      $display("ERROR irq wait exp 1 got %b", irq);
      end_of_test();
    end
  endtask
  task automatic half(input int exp, input string what);
    logic v;
    int   i;
    v = int_tx_clk_out;
    for (i = 0; i < 99 && int_tx_clk_out === v; i++) @(negedge clock);
    v = int_tx_clk_out;
    for (i = 0; i < 99 && int_tx_clk_out === v; i++) @(negedge clock);
    chk(what, exp, i);
  endtask
  task automatic t_regs();
    rd(OFS_CTRL, 32'h0, "ctrl");
    rd(OFS_CLKDIV, 32'h0000000c, "clkdiv");
    rd(OFS_INT_EN, 32'h0, "int_en");
    rd(OFS_INT_ST, 32'h0, "int_st");
    rd(8'h20, 32'h0, "unmapped");
    wr(OFS_STATUS, 32'h1f);
    rd(OFS_STATUS, 32'h6, "status");
    rd(OFS_INT_CL, 32'h0, "int_cl");
  endtask
  // sampled bit must match the settled pin level once locked
  task automatic bit_chk();
    int i;
    for (i = 0; i < 40 && tx_bit_valid !== 1'b1; i++) @(negedge clock);
    chk("tx_bit_valid", 1, tx_bit_valid);
    chk("tx_bit", pins_in.tx_data, tx_bit);
  endtask
  task automatic phase_run();
    @(posedge clock);
    skew <= 4'h1;
    run <= 1'b1;
    wait_irq();
    bit_chk();
    rd(OFS_STATUS, 32'h7, "phase fall");
    rd(OFS_INT_ST, 32'h1, "switch event");
    wr(OFS_INT_CL, 32'h1);
    skew <= 4'h9;
    cyc(3);
    chk("irq cleared", 0, irq);
    wait_irq();
    bit_chk();
    rd(OFS_STATUS, 32'h6, "phase rise");
    wr(OFS_INT_CL, 32'h1);
    run <= 1'b0;
  endtask
  task automatic t_ext();
    wr(OFS_INT_EN, 32'h1);
    wr(OFS_CTRL, 32'h2);
    phase_run();
  endtask
  task automatic t_int();
    wr(OFS_CLKDIV, 32'h7);
    wr(OFS_CTRL, 32'h0);
    use_int <= 1'b1;
    phase_run();
    half(8, "int half");
    wr(OFS_CTRL, 32'h1);
    tick_en <= 1'b1;
    cyc(8);
    half(4, "rx half");
    // source code 3 runs the divider and ignores the ticks
    wr(OFS_CTRL, 32'h3);
    cyc(12);
    half(8, "src3 half");
  endtask
  task automatic t_alarm();
    wr(OFS_INT_EN, 32'h6);
    rts <= 1'b0;
    cyc(8);
    chk("alarm off", 0, handshake_alarm);
    rd(OFS_INT_ST, 32'h0, "no event");
    wr(OFS_CTRL, 32'h4);
    cyc(3);
    chk("alarm rts", 1, handshake_alarm);
    @(posedge clock);
    rts <= 1'b1;
    cyc(6);
    chk("alarm gone", 0, handshake_alarm);
    @(posedge clock);
    rts <= 1'b0;
    wait_irq();
    rd(OFS_INT_ST, 32'h2, "rts event");
    @(posedge clock);
    rts <= 1'b1;
    wr(OFS_INT_CL, 32'h7);
    cyc(3);
    chk("irq cleared", 0, irq);
    @(posedge clock);
    dtr <= 1'b0;
    wait_irq();
    chk("alarm dtr", 1, handshake_alarm);
    rd(OFS_INT_ST, 32'h4, "dtr event");
    @(posedge clock);
    dtr <= 1'b1;
    wr(OFS_CTRL, 32'h8);
    cyc(6);
    chk("carrier on", 1, carrier_on);
    @(posedge clock);
    rts <= 1'b0;
    cyc(6);
    chk("carrier off", 0, carrier_on);
    rd(OFS_STATUS, 32'h4, "status rts");
    @(posedge clock);
    rts <= 1'b1;
    wr(OFS_CTRL, 32'h10);
    cyc(3);
    chk("carrier force", 1, carrier_on);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs();
    t_ext();
    t_int();
    t_alarm();
    end_of_test();
  end
endmodule
`default_nettype wire

// File: verification/term_model.sv
`timescale 1ns/1ps
`default_nettype none
module term_model
  import serial_port_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   run,
  input  wire logic                   use_int,
  input  wire logic                   int_clk,
  input  wire logic [3:0]             skew,
  input  wire logic                   rts,
  input  wire logic                   dtr,
  output var  serial_port_pkg::pins_t pins
);
  logic [3:0] cnt_ff = 4'h0;
  logic [3:0] age_ff = 4'h0;
  logic       dat_ff = 1'b0;
  logic       ref_ff = 1'b0;
  logic       own_clk;
  logic       ref_clk;
  // own clock stands still outside frames
  assign own_clk = run && !use_int && cnt_ff[3];
  // data launched a set delay after the chosen clock rise
  assign ref_clk = use_int ? int_clk : own_clk;
  always_ff @(posedge clock) begin
    cnt_ff <= run ? cnt_ff + 4'h1 : 4'h0;
    ref_ff <= ref_clk;
    age_ff <= (ref_clk && !ref_ff) ? 4'h0 : age_ff + 4'h1;
    if (run && age_ff == skew) dat_ff <= !dat_ff;
  end
  assign pins = '{dtr: dtr, rts: rts, tx_data: dat_ff, tx_clk: own_clk};
endmodule
`default_nettype wire
